// *** tpo_pkg.sv ***
package tpo_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] TPO_MODE_OFF = 8'h00;
    localparam logic [7:0] TPO_CAPCMP_OFF = 8'h04;
    localparam logic [7:0] TPO_OUTCTL_OFF = 8'h08;
    localparam logic [7:0] TPO_PRESC_OFF = 8'h0C;
    localparam logic [7:0] TPO_CMPA_OFF = 8'h10;
    localparam logic [7:0] TPO_CMPB_OFF = 8'h14;
    localparam logic [7:0] TPO_COUNT_OFF = 8'h18;

    // ==========================================
    // Field positions
    localparam int TPO_OVF_BIT = 0;
    localparam int TPO_MODE_LO_BIT = 2;
    localparam int TPO_MODE_HI_BIT = 3;
    localparam int TPO_CAPB_BIT = 0;
    localparam int TPO_OE_BIT = 0;
    localparam int TPO_TOGA_BIT = 1;
    localparam int TPO_PPG_BIT = 2;
    localparam int TPO_OSEN_BIT = 4;
    localparam int TPO_OSPT_BIT = 6;
    localparam int TPO_CKSEL_LO_BIT = 0;
    localparam int TPO_CKSEL_HI_BIT = 1;
    localparam int TPO_ES_LO_BIT = 4;
    localparam int TPO_ES_HI_BIT = 5;

    // ==========================================
    // Reset values and counter maximum
    localparam logic [15:0] TPO_CMP_RST = 16'h0000;
    localparam logic [15:0] TPO_COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] TPO_REG_RST = 8'h00;

    // ==========================================
    // Count clock division ratios, one per select code
    localparam int TPO_DIV0 = 1;
    localparam int TPO_DIV1 = 2;
    localparam int TPO_DIV2 = 4;
    localparam int TPO_DIV3 = 8;

    // ==========================================
    // Counter modes
    typedef enum logic [1:0] {
        TPO_MODE_STOP = 2'b00,
        TPO_MODE_EDGE_CLR = 2'b01,
        TPO_MODE_FREE = 2'b10,
        TPO_MODE_MATCH_CLR = 2'b11
    } tpo_mode_t;

    // Edge selection
    typedef enum logic [1:0] {
        TPO_ES_FALL = 2'b00,
        TPO_ES_RISE = 2'b01,
        TPO_ES_NONE = 2'b10,
        TPO_ES_BOTH = 2'b11
    } tpo_edge_t;
endpackage

// *** tpo_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module tpo_sync
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic sync_out
);
    import tpo_pkg::*;
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // tpo_sync
`default_nettype wire

// *** tpo_prescale.sv ***
`timescale 1ns/1ns
`default_nettype none
module tpo_prescale
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [1:0] sel_in,
    output logic tick_out
);
    import tpo_pkg::*;
    logic [2:0] div_q;
    logic [2:0] last;

    always_comb
    begin
        case (sel_in)
            2'b00: last = 3'(TPO_DIV0 - 1);
            2'b01: last = 3'(TPO_DIV1 - 1);
            2'b10: last = 3'(TPO_DIV2 - 1);
            default: last = 3'(TPO_DIV3 - 1);
        endcase
    end

    // Divider restarts whenever the counter is stopped
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !run_in || div_q >= last)
            div_q <= 3'h0;
        else
            div_q <= div_q + 3'h1;
    end

    assign tick_out = run_in && (div_q >= last);
endmodule // tpo_prescale
`default_nettype wire

// *** tpo_timer.sv ***
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Restart mode edge captures count, then clears
// - Rising or falling capture edge selectable
// - Trigger sampled, two equal samples required
// - Both-edges selection performs no capture
// - Square wave inverts every compare_a+1 counts in match-clear mode
// - Counter clears on compare_a only in match-clear mode, in square mode too
// - Pulse generator: cycle compare_a, width compare_b
// - Period compare_a+1, duty (compare_b+1)/(compare_a+1)
// - One-shot by software or external edge
// - Trigger bit clears, starts, pulses on matches
// - compare_b below compare_a swaps active order
// - Counter keeps running after one-shot
// - Software trigger also restarts a running one-shot
// - External one-shot edge selectable, any edge
// - Edges during a pulse are ignored
// - Counter runs once mode bits nonzero
// - compare_a match raises request, clears counter in match-clear mode
// - Overflow flag set on FFFF to 0000, not when a compare_a match clears FFFF in match-clear mode
module tpo_timer
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic trigger_input_in,
    output logic wave_output_out,
    output logic match_a_irq_out
);
    import tpo_pkg::*;

    // ==========================================
    // Register state
    logic [7:0] mode_control_reg_q;
    logic [7:0] capcmp_control_reg_q;
    logic [7:0] output_control_reg_q;
    logic [7:0] prescaler_reg_q;
    logic [15:0] compare_a_q;
    logic [15:0] compare_b_q;
    logic [15:0] count_value_q;
    logic overflow_flag_q;
    logic wave_q;
    logic busy_q;
    logic irq_q;
    logic [31:0] rdata_q;

    // ==========================================
    // Decode
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic tick;
    logic trig_sync;
    logic samp1_q;
    logic samp2_q;
    logic lvl_q;
    logic lvl_valid_q;
    logic edge_rise;
    logic edge_fall;
    logic edge_hit;
    logic sw_trig;
    logic os_start;
    logic capture;
    logic match_a;
    logic match_b;
    logic running;
    logic ovf_event;
    logic ovf_clear;
    logic ppg_mode;
    tpo_mode_t mode;
    tpo_edge_t edge_sel;

    assign mode = tpo_mode_t'(mode_control_reg_q[TPO_MODE_HI_BIT:TPO_MODE_LO_BIT]);
    assign edge_sel = tpo_edge_t'(prescaler_reg_q[TPO_ES_HI_BIT:TPO_ES_LO_BIT]);
    assign running = (mode != TPO_MODE_STOP);

    always_comb
    begin
        case (paddr_in)
            TPO_MODE_OFF, TPO_CAPCMP_OFF, TPO_OUTCTL_OFF, TPO_PRESC_OFF,
            TPO_CMPA_OFF, TPO_CMPB_OFF, TPO_COUNT_OFF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_acc = psel_in && penable_in && pwrite_in && addr_ok;
    assign rd_acc = psel_in && !penable_in && !pwrite_in;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;
    assign prdata_out = rdata_q;

    // ==========================================
    // Count clock and trigger input path
    tpo_prescale u_prescale
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(running),
        .sel_in(prescaler_reg_q[TPO_CKSEL_HI_BIT:TPO_CKSEL_LO_BIT]),
        .tick_out(tick)
    );

    tpo_sync u_sync
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(trigger_input_in),
        .sync_out(trig_sync)
    );

    // Sample at count clock; level accepted after two equal samples
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !running)
        begin
            samp1_q <= 1'b0;
            samp2_q <= 1'b0;
            lvl_q <= 1'b0;
            lvl_valid_q <= 1'b0;
        end
        else if (tick)
        begin
            samp1_q <= trig_sync;
            samp2_q <= samp1_q;
            if (samp1_q == samp2_q)
            begin
                lvl_q <= samp2_q;
                lvl_valid_q <= 1'b1;
            end
        end
    end

    // Edge from change in the accepted level
    logic lvl_prev_q;
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !running)
            lvl_prev_q <= 1'b0;
        else if (tick)
            lvl_prev_q <= lvl_q;
    end

    assign edge_rise = tick && lvl_valid_q && lvl_q && !lvl_prev_q;
    assign edge_fall = tick && lvl_valid_q && !lvl_q && lvl_prev_q;

    always_comb
    begin
        case (edge_sel)
            TPO_ES_FALL: edge_hit = edge_fall;
            TPO_ES_RISE: edge_hit = edge_rise;
            TPO_ES_BOTH: edge_hit = edge_rise || edge_fall;
            default: edge_hit = 1'b0;
        endcase
    end

    // Restart capture only for single-edge selection; compare_a never captures
    assign capture = edge_hit && (mode == TPO_MODE_EDGE_CLR) && capcmp_control_reg_q[TPO_CAPB_BIT] &&
                     (edge_sel != TPO_ES_BOTH);

    // ==========================================
    // One-shot start
    assign sw_trig = wr_acc && (paddr_in == TPO_OUTCTL_OFF) && pwdata_in[TPO_OSPT_BIT] && running;
    assign os_start = output_control_reg_q[TPO_OSEN_BIT] && running &&
                      (sw_trig || (edge_hit && !busy_q));

    // ==========================================
    // Compare matches on count clock
    assign match_a = tick && (count_value_q == compare_a_q);
    assign match_b = tick && (count_value_q == compare_b_q);
    assign ppg_mode = output_control_reg_q[TPO_PPG_BIT] && (mode == TPO_MODE_MATCH_CLR);
    assign ovf_event = tick && (count_value_q == TPO_COUNT_MAX) &&
                       !(mode == TPO_MODE_MATCH_CLR && match_a);

    // ==========================================
    // Counter
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !running)
            count_value_q <= TPO_CMP_RST;
        else if (os_start || (edge_hit && mode == TPO_MODE_EDGE_CLR && !busy_q))
            count_value_q <= TPO_CMP_RST;
        else if (mode == TPO_MODE_MATCH_CLR && match_a)
            count_value_q <= TPO_CMP_RST;
        else if (tick)
            count_value_q <= count_value_q + 16'h0001;
    end

    // ==========================================
    // Compare match request pulse
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            irq_q <= 1'b0;
        else
            irq_q <= running && match_a;
    end

    assign match_a_irq_out = irq_q;

    // ==========================================
    // Overflow flag, set wins over software clear
    assign ovf_clear = wr_acc && (paddr_in == TPO_MODE_OFF) && !pwdata_in[TPO_OVF_BIT];

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            overflow_flag_q <= 1'b0;
        else if (running && ovf_event)
            overflow_flag_q <= 1'b1;
        else if (ovf_clear)
            overflow_flag_q <= 1'b0;
    end

    // ==========================================
    // One-shot busy tracking
    logic os_end;
    assign os_end = (compare_b_q < compare_a_q) ? match_a : match_b;

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !running)
            busy_q <= 1'b0;
        else if (os_start)
            busy_q <= 1'b1;
        else if (busy_q && os_end)
            busy_q <= 1'b0;
    end

    // ==========================================
    // Wave output level
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !running)
            wave_q <= 1'b0;
        else if (output_control_reg_q[TPO_OSEN_BIT])
        begin
            if (busy_q && !os_start)
            begin
                if (compare_b_q < compare_a_q)
                begin
                    if (match_b)
                        wave_q <= 1'b1;
                    else if (match_a)
                        wave_q <= 1'b0;
                end
                else
                begin
                    if (match_a)
                        wave_q <= 1'b1;
                    else if (match_b)
                        wave_q <= 1'b0;
                end
            end
            else if (!busy_q)
                wave_q <= 1'b0;
        end
        else if (ppg_mode)
        begin
            if (match_a)
                wave_q <= 1'b1;
            else if (match_b)
                wave_q <= 1'b0;
        end
        else if (output_control_reg_q[TPO_TOGA_BIT] && match_a)
            wave_q <= !wave_q;
    end

    assign wave_output_out = output_control_reg_q[TPO_OE_BIT] && wave_q;

    // ==========================================
    // Control registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            mode_control_reg_q <= TPO_REG_RST;
            capcmp_control_reg_q <= TPO_REG_RST;
            output_control_reg_q <= TPO_REG_RST;
            prescaler_reg_q <= TPO_REG_RST;
        end
        else if (wr_acc)
        begin
            case (paddr_in)
                TPO_MODE_OFF: mode_control_reg_q <= {4'h0, pwdata_in[TPO_MODE_HI_BIT:TPO_MODE_LO_BIT], 2'b00};
                TPO_CAPCMP_OFF: capcmp_control_reg_q <= {7'h00, pwdata_in[TPO_CAPB_BIT]};
                TPO_OUTCTL_OFF: output_control_reg_q <= {1'b0, 1'b0, pwdata_in[5:0]};
                TPO_PRESC_OFF: prescaler_reg_q <= {2'b00, pwdata_in[5:4], 2'b00, pwdata_in[1:0]};
                default: mode_control_reg_q <= mode_control_reg_q;
            endcase
        end
    end

    // ==========================================
    // Compare registers, capture wins over software write
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            compare_a_q <= TPO_CMP_RST;
        else if (wr_acc && paddr_in == TPO_CMPA_OFF)
            compare_a_q <= pwdata_in[15:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            compare_b_q <= TPO_CMP_RST;
        else if (capture)
            compare_b_q <= count_value_q;
        else if (wr_acc && paddr_in == TPO_CMPB_OFF)
            compare_b_q <= pwdata_in[15:0];
    end

    // ==========================================
    // Read data, latched in the setup cycle
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_q <= 32'h0000_0000;
        else if (rd_acc)
        begin
            case (paddr_in)
                TPO_MODE_OFF: rdata_q <= {24'h000000, mode_control_reg_q[7:1], overflow_flag_q};
                TPO_CAPCMP_OFF: rdata_q <= {24'h000000, capcmp_control_reg_q};
                TPO_OUTCTL_OFF: rdata_q <= {24'h000000, output_control_reg_q[7], busy_q, output_control_reg_q[5:0]};
                TPO_PRESC_OFF: rdata_q <= {24'h000000, prescaler_reg_q};
                TPO_CMPA_OFF: rdata_q <= {16'h0000, compare_a_q};
                TPO_CMPB_OFF: rdata_q <= {16'h0000, compare_b_q};
                TPO_COUNT_OFF: rdata_q <= {16'h0000, count_value_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
endmodule // tpo_timer
`default_nettype wire

// *** tpo_timer_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module tpo_timer_assertions
import tpo_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic wave_output_out,
    input wire logic match_a_irq_out
);
    wire logic mapped;
    assign mapped = (paddr_in <= TPO_COUNT_OFF) && (paddr_in[1:0] == 2'h0);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ==========================================
    // Bus phases
    sequence s_acc;
        psel_in && penable_in;
    endsequence
    sequence s_bad_rd;
        psel_in && !penable_in && !pwrite_in && !mapped;
    endsequence
    sequence s_stop_wr;
        s_acc ##0 (pwrite_in && paddr_in == TPO_MODE_OFF && pwdata_in[3:2] == 2'h0);
    endsequence
    sequence s_oe_off;
        s_acc ##0 (pwrite_in && paddr_in == TPO_OUTCTL_OFF && !pwdata_in[0]);
    endsequence
    // ==========================================
    // Checks
    AST_READY: assert property (pready_out)
        else $error("ready dropped");
    AST_ERR_UNMAPPED: assert property (psel_in && penable_in && !mapped |-> pslverr_out)
        else $error("no error on unmapped access");
    AST_ERR_MAPPED: assert property (psel_in && penable_in && mapped |-> !pslverr_out)
        else $error("error on mapped access");
    AST_RDATA_UNMAPPED: assert property (s_bad_rd ##1 s_acc |-> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_STOP_QUIET: assert property (s_stop_wr |=> ##1 !match_a_irq_out [*3])
        else $error("match pulse while stopped");
    AST_OE_OFF: assert property (s_oe_off |=> !wave_output_out [*2])
        else $error("wave active with output disabled");
    AST_IRQ_PULSE: assert property (match_a_irq_out |=> !match_a_irq_out)
        else $error("match pulse too long");
    AST_RESET_IDLE: assert property ($fell(rst_in) |-> !wave_output_out && !match_a_irq_out)
        else $error("outputs busy after reset");
endmodule // tpo_timer_assertions
`default_nettype wire

// *** tpo_trig_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module tpo_trig_model
(
    input wire logic clk_in,
    output logic trig_out
);
    initial trig_out = 1'h0;
    // ==========================================
    // Set a pin level, hold it n more clocks
    task automatic drive(input logic lvl, input int n);
        @(posedge clk_in);
        trig_out <= lvl;
        repeat (n) @(posedge clk_in);
    endtask
endmodule // tpo_trig_model
`default_nettype wire

// *** test_tpo_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_tpo_timer;
    import tpo_pkg::*;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic psel_in = 1'h0;
    logic penable_in = 1'h0;
    logic pwrite_in = 1'h0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rd, c;
    logic pready_out, pslverr_out, trigger_input_in, wave_output_out, match_a_irq_out, err;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    always #25 clk_in = ~clk_in;
    tpo_timer uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .trigger_input_in(trigger_input_in),
        .wave_output_out(wave_output_out), .match_a_irq_out(match_a_irq_out));
    tpo_trig_model trg (.clk_in(clk_in), .trig_out(trigger_input_in));
    // ==========================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            failures++;
            results();
        end
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        paddr_in <= a;
        pwrite_in <= w;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        do @(posedge clk_in); while (pready_out !== 1'h1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task automatic stop();
        apb(TPO_MODE_OFF, 1'h1, 32'h0);
        apb(TPO_OUTCTL_OFF, 1'h1, 32'h0);
    endtask
    // Clocks until the wave pin shows v
    task automatic ww(input logic v);
        n = 0;
        while (wave_output_out !== v && n < 3000)
        begin
            @(posedge clk_in);
            n++;
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        check(wave_output_out, 1'h0);
        check(match_a_irq_out, 1'h0);
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        check(rd, 32'h0);
        apb(8'h20, 1'h1, 32'hFFFFFFFF);
        check(err, 1'h1);
        apb(8'h20, 1'h0, 32'h0);
        check(rd, 32'h0);
        apb(TPO_MODE_OFF, 1'h0, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_run();
        apb(TPO_MODE_OFF, 1'h1, 32'h8);
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        c = rd;
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        check(rd - c, 32'h3);
        apb(TPO_PRESC_OFF, 1'h1, 32'h3);
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        c = rd;
        repeat (29) @(posedge clk_in);
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        check(rd - c, 32'h4);
        apb(TPO_PRESC_OFF, 1'h1, 32'h0);
        stop();
        apb(TPO_COUNT_OFF, 1'h0, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_square();
        apb(TPO_CMPA_OFF, 1'h1, 32'h4);
        apb(TPO_OUTCTL_OFF, 1'h1, 32'h3);
        apb(TPO_MODE_OFF, 1'h1, 32'hC);
        ww(1'h1);
        ww(1'h0);
        check(n, 32'h5);
        ww(1'h1);
        check(n, 32'h5);
        n = 0;
        repeat (25)
        begin
            @(posedge clk_in);
            n = n + int'(match_a_irq_out);
        end
        check(n, 32'h5);
        ww(1'h1);
        apb(TPO_OUTCTL_OFF, 1'h1, 32'h2);
        @(posedge clk_in);
        check(wave_output_out, 1'h0);
        stop();
    endtask
    task automatic t_ppg();
        apb(TPO_CMPA_OFF, 1'h1, 32'h9);
        apb(TPO_CMPB_OFF, 1'h1, 32'h3);
        apb(TPO_OUTCTL_OFF, 1'h1, 32'h5);
        apb(TPO_MODE_OFF, 1'h1, 32'hC);
        ww(1'h1);
        ww(1'h0);
        check(n, 32'h4);
        ww(1'h1);
        check(n, 32'h6);
        stop();
    endtask
    task automatic t_sw();
        for (int i = 0; i < 2; i++)
        begin
            apb(TPO_CMPA_OFF, 1'h1, i ? 32'h5 : 32'h14);
            apb(TPO_CMPB_OFF, 1'h1, i ? 32'h14 : 32'h5);
            apb(TPO_MODE_OFF, 1'h1, 32'h8);
            apb(TPO_OUTCTL_OFF, 1'h1, 32'h11);
            apb(TPO_OUTCTL_OFF, 1'h1, 32'h51);
            ww(1'h1);
            ww(1'h0);
            check(n, 32'hF);
            apb(TPO_COUNT_OFF, 1'h0, 32'h0);
            c = rd;
            apb(TPO_COUNT_OFF, 1'h0, 32'h0);
            check(rd - c, 32'h3);
            stop();
        end
    endtask
    task automatic t_ext();
        logic [1:0] code;
        logic act;
        for (int i = 0; i < 3; i++)
        begin
            code = (i == 0) ? TPO_ES_RISE : (i == 1) ? TPO_ES_FALL : TPO_ES_BOTH;
            act = (code != TPO_ES_FALL);
            apb(TPO_PRESC_OFF, 1'h1, {26'h0, code, 4'h0});
            apb(TPO_CMPA_OFF, 1'h1, 32'h1E);
            apb(TPO_CMPB_OFF, 1'h1, 32'h5);
            apb(TPO_OUTCTL_OFF, 1'h1, 32'h11);
            apb(TPO_MODE_OFF, 1'h1, 32'h8);
            trg.drive(act, 6);
            ww(1'h1);
            trg.drive(!act, 4);
            trg.drive(act, 4);
            ww(1'h0);
            check(n + 10, 32'h19);
            stop();
        end
    endtask
    task automatic t_cap();
        logic [1:0] code;
        logic act;
        apb(TPO_CMPA_OFF, 1'h1, 32'h777);
        for (int i = 0; i < 3; i++)
        begin
            code = (i == 0) ? TPO_ES_RISE : (i == 1) ? TPO_ES_FALL : TPO_ES_BOTH;
            act = (code != TPO_ES_FALL);
            trg.drive(!act, 8);
            apb(TPO_PRESC_OFF, 1'h1, {26'h0, code, 4'h0});
            apb(TPO_CAPCMP_OFF, 1'h1, 32'h1);
            apb(TPO_CMPB_OFF, 1'h1, 32'h1234);
            apb(TPO_MODE_OFF, 1'h1, 32'h4);
            trg.drive(act, 0);
            trg.drive(!act, 10);
            apb(TPO_CMPB_OFF, 1'h0, 32'h0);
            check(rd, 32'h1234);
            trg.drive(act, 10);
            trg.drive(!act, 28);
            trg.drive(act, 10);
            trg.drive(!act, 10);
            apb(TPO_CMPB_OFF, 1'h0, 32'h0);
            check(rd, (i == 2) ? 32'h1234 : 32'h27);
            apb(TPO_CMPA_OFF, 1'h0, 32'h0);
            check(rd, 32'h777);
            stop();
        end
    endtask
    task automatic t_ovf();
        apb(TPO_MODE_OFF, 1'h1, 32'h8);
        repeat (65540) @(posedge clk_in);
        apb(TPO_MODE_OFF, 1'h0, 32'h0);
        check(rd[0], 1'h1);
        apb(TPO_MODE_OFF, 1'h1, 32'h8);
        apb(TPO_MODE_OFF, 1'h0, 32'h0);
        check(rd[0], 1'h0);
        stop();
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_run();
        t_square();
        t_ppg();
        t_sw();
        t_ext();
        t_cap();
        t_ovf();
        results();
    end
endmodule // test_tpo_timer
bind tpo_timer tpo_timer_assertions chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .wave_output_out(wave_output_out), .match_a_irq_out(match_a_irq_out));
`default_nettype wire
